// ==== logic/cspm_map.svh ====
`ifndef CSPM_MAP_SVH
`define CSPM_MAP_SVH

// ****************************************
// Register map and field layout
// ****************************************
`define CSPM_OSCCTL_OFFSET 32'h0000_0000
`define CSPM_IDLE_BIT 7
`define CSPM_FREQ_HI 6
`define CSPM_FREQ_LO 4
`define CSPM_STT_BIT 3
`define CSPM_IOS_BIT 2
`define CSPM_SRC_HI 1
`define CSPM_SRC_LO 0
`define CSPM_RST_IDLE 1'h0
`define CSPM_RST_FREQ 3'h0
`define CSPM_RST_SRC 2'h0

// ****************************************
// Timing
// ****************************************
`define CSPM_CLK_MHZ 25
`define CSPM_OST_TICKS 1024
`define CSPM_SWITCH_TICKS 8
`define CSPM_FAST_STABLE_TICKS 16
`define CSPM_PLL_LOCK_US 2000
`define CSPM_POWERUP_TIMER_US 1000
`define CSPM_READY_MIN_US 5
`define CSPM_PLL_CYC (`CSPM_PLL_LOCK_US * `CSPM_CLK_MHZ)
`define CSPM_POWERUP_TIMER_CYC (`CSPM_POWERUP_TIMER_US * `CSPM_CLK_MHZ)
`define CSPM_READY_CYC (`CSPM_READY_MIN_US * `CSPM_CLK_MHZ)

`endif

// ==== logic/cspm_pkg.sv ====
package cspm_pkg;

   // Power managed modes.
   typedef enum logic [2:0] {
      CSPM_PRIMARY_RUN_MODE, CSPM_PRIMARY_IDLE_MODE, CSPM_SECONDARY_RUN_MODE, CSPM_SECONDARY_IDLE_MODE,
      CSPM_INT_RUN, CSPM_INT_IDLE, CSPM_SLEEP
   } cspm_mode_t;

   // Primary oscillator configuration.
   typedef enum logic [3:0] {
      CSPM_LP, CSPM_XT, CSPM_HS, CSPM_CRYSTAL_PLL_MODE, CSPM_RC, CSPM_RESISTOR_CAP_IO_MODE,
      CSPM_EC, CSPM_EXTERNAL_CLOCK_IO_MODE, CSPM_INT_CLKOUT, CSPM_INT_IO
   } cspm_osc_cfg_t;

   // Configuration straps.
   typedef struct packed {
      cspm_osc_cfg_t osc_cfg;
      logic two_speed_start_cfg;
      logic powerup_timer_en;
      logic watchdog_en;
      logic sec_osc_on;
      logic sec_keep_run;
   } cspm_cfg_t;

   // Oscillator ticks or enables, one bit per source.
   typedef struct packed {
      logic prim;
      logic sec;
      logic fast;
      logic slow;
   } cspm_osc_t;

endpackage

// ==== logic/cspm_ctrl.sv ====
`timescale 1ns/10ps
`include "cspm_map.svh"

module cspm_ctrl #(
   parameter int ADDR_W = 4,
   parameter int POWERUP_TIMER_CYC = `CSPM_POWERUP_TIMER_CYC,
   parameter int PLL_CYC = `CSPM_PLL_CYC
) (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ce,
   // AXI4-Lite slave
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Configuration and events
   input wire cspm_pkg::cspm_cfg_t cfg,
   input wire cspm_pkg::cspm_osc_t osc_tick,
   input wire logic sleep_trigger,
   input wire logic wake_interrupt,
   input wire logic wake_reset,
   input wire logic wake_watchdog,
   input wire logic port_bit6_out,
   input wire logic port_bit6_oe,
   // Clock outputs and status
   output cspm_pkg::cspm_osc_t osc_enable,
   output logic sys_tick,
   output logic cpu_tick,
   output logic periph_tick,
   output logic device_reset_hold,
   output logic exec_ready,
   output cspm_pkg::cspm_mode_t mode,
   output logic xtal_feedback_en,
   output logic second_oscillator_pin_out,
   output logic second_oscillator_pin_oe
);

   // ****************************************
   // State
   // ****************************************
   cspm_pkg::cspm_mode_t mode_reg, mode_next;
   logic idle_select_reg;
   logic [2:0] internal_freq_select_reg;
   logic [1:0] clock_source_select_reg;
   logic startup_timer_done_reg;
   logic internal_osc_stable_reg;
   logic pause_reg;
   logic [3:0] pause_cnt_reg;
   logic [10:0] ost_cnt_reg;
   logic [6:0] post_cnt_reg;
   logic [4:0] fast_cnt_reg;
   logic [31:0] powerup_timer_cnt_reg;
   logic [31:0] pll_cnt_reg;
   logic [7:0] ready_cnt_reg;
   logic clkout_reg;
   logic aw_full_reg, w_full_reg;
   logic [ADDR_W-1:0] aw_addr_reg;
   logic [7:0] w_data_reg;
   logic w_strb_reg;

   logic src_pri, src_sec, src_int;
   logic ost_done, pll_done, powerup_timer_done, ready_done, por_hold;
   logic trig_ok, wake_any, int_tick, src_tick, new_src_diff;
   logic xtal_mode, clkout_mode, prim_internal;
   logic [6:0] post_mask;
   cspm_pkg::cspm_osc_t en_next;
   logic [7:0] reg_value;

   // ****************************************
   // Mode decode
   // ****************************************
   // The source follows the active mode, never the select field directly.
   always_comb begin
      src_pri = (mode_reg == cspm_pkg::CSPM_PRIMARY_RUN_MODE) || (mode_reg == cspm_pkg::CSPM_PRIMARY_IDLE_MODE);
      src_sec = (mode_reg == cspm_pkg::CSPM_SECONDARY_RUN_MODE) || (mode_reg == cspm_pkg::CSPM_SECONDARY_IDLE_MODE);
      src_int = (mode_reg == cspm_pkg::CSPM_INT_RUN) || (mode_reg == cspm_pkg::CSPM_INT_IDLE);
      xtal_mode = (cfg.osc_cfg == cspm_pkg::CSPM_LP) || (cfg.osc_cfg == cspm_pkg::CSPM_XT) ||
                  (cfg.osc_cfg == cspm_pkg::CSPM_HS) || (cfg.osc_cfg == cspm_pkg::CSPM_CRYSTAL_PLL_MODE);
      clkout_mode = (cfg.osc_cfg == cspm_pkg::CSPM_RC) || (cfg.osc_cfg == cspm_pkg::CSPM_EC) ||
                    (cfg.osc_cfg == cspm_pkg::CSPM_INT_CLKOUT);
      prim_internal = (cfg.osc_cfg == cspm_pkg::CSPM_INT_CLKOUT) ||
                      (cfg.osc_cfg == cspm_pkg::CSPM_INT_IO);
   end

   // Next mode on a trigger or a wake event; wake wins over a trigger.
   always_comb begin
      trig_ok = sleep_trigger && exec_ready && !cpu_idle(mode_reg);
      wake_any = wake_interrupt || wake_reset || wake_watchdog;
      mode_next = mode_reg;
      if (wake_any) begin
         mode_next = cspm_pkg::CSPM_PRIMARY_RUN_MODE;
      end else if (trig_ok) begin
         // Bits as they stand now decide the mode.
         if (clock_source_select_reg[1]) begin
            mode_next = idle_select_reg ? cspm_pkg::CSPM_INT_IDLE : cspm_pkg::CSPM_INT_RUN;
         end else if (clock_source_select_reg[0]) begin
            // A stopped secondary oscillator makes the trigger a no-op.
            if (cfg.sec_osc_on) begin
               mode_next = idle_select_reg ? cspm_pkg::CSPM_SECONDARY_IDLE_MODE : cspm_pkg::CSPM_SECONDARY_RUN_MODE;
            end
         end else begin
            mode_next = idle_select_reg ? cspm_pkg::CSPM_PRIMARY_IDLE_MODE : cspm_pkg::CSPM_SLEEP;
         end
      end
      new_src_diff = (src_of(mode_next) != src_of(mode_reg)) &&
                     (mode_next != cspm_pkg::CSPM_SLEEP);
   end

   function automatic logic cpu_idle(input cspm_pkg::cspm_mode_t m);
      cpu_idle = (m == cspm_pkg::CSPM_PRIMARY_IDLE_MODE) || (m == cspm_pkg::CSPM_SECONDARY_IDLE_MODE) ||
                 (m == cspm_pkg::CSPM_INT_IDLE) || (m == cspm_pkg::CSPM_SLEEP);
   endfunction

   function automatic logic [1:0] src_of(input cspm_pkg::cspm_mode_t m);
      if ((m == cspm_pkg::CSPM_SECONDARY_RUN_MODE) || (m == cspm_pkg::CSPM_SECONDARY_IDLE_MODE)) begin
         src_of = 2'h1;
      end else if ((m == cspm_pkg::CSPM_INT_RUN) || (m == cspm_pkg::CSPM_INT_IDLE)) begin
         src_of = 2'h2;
      end else if (m == cspm_pkg::CSPM_SLEEP) begin
         src_of = 2'h3;
      end else begin
         src_of = 2'h0;
      end
   endfunction

   // Mode register.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         mode_reg <= cspm_pkg::CSPM_PRIMARY_RUN_MODE;
      end else if (ce) begin
         mode_reg <= mode_next;
      end
   end

   // ****************************************
   // Clock selection and switch pause
   // ****************************************
   // Postscaler: the mask shrinks as the field grows, 111 passes every tick.
   always_comb begin
      post_mask = 7'h7f >> internal_freq_select_reg;
      if (internal_freq_select_reg == 3'h0) begin
         int_tick = osc_tick.slow;
      end else begin
         int_tick = osc_tick.fast && ((post_cnt_reg & post_mask) == post_mask);
      end
      if (src_sec) begin
         src_tick = osc_tick.sec;
      end else if (src_int) begin
         src_tick = int_tick;
      end else if (src_pri) begin
         src_tick = osc_tick.prim;
      end else begin
         src_tick = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         post_cnt_reg <= 7'h00;
      end else if (ce && osc_tick.fast) begin
         post_cnt_reg <= post_cnt_reg + 7'h01;
      end
   end

   // Counting ticks of the new source after the request gives 7 to 8 of
   // its periods, since the request lands anywhere inside one period.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pause_reg <= 1'b0;
         pause_cnt_reg <= 4'h0;
      end else if (ce) begin
         if (new_src_diff) begin
            pause_reg <= 1'b1;
            pause_cnt_reg <= 4'h0;
         end else if (pause_reg && src_tick) begin
            if (pause_cnt_reg == 4'(`CSPM_SWITCH_TICKS - 1)) begin
               pause_reg <= 1'b0;
            end
            pause_cnt_reg <= pause_cnt_reg + 4'h1;
         end
      end
   end

   // Gated system, core and peripheral ticks.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         sys_tick <= 1'b0;
         cpu_tick <= 1'b0;
         periph_tick <= 1'b0;
      end else if (ce) begin
         sys_tick <= src_tick && !pause_reg && !por_hold;
         cpu_tick <= src_tick && !pause_reg && !por_hold && !cpu_idle(mode_reg);
         periph_tick <= src_tick && !pause_reg && !por_hold;
      end
   end

   // ****************************************
   // Oscillator enables and pins
   // ****************************************
   always_comb begin
      en_next.prim = src_pri;
      en_next.sec = src_sec || cfg.sec_keep_run;
      en_next.fast = (internal_freq_select_reg != 3'h0) &&
                     (src_int || (src_pri && prim_internal));
      en_next.slow = cfg.watchdog_en ||
                     ((internal_freq_select_reg == 3'h0) && src_int);
   end

   // In Sleep the clock output modes park the pin low and I/O modes hand
   // it to the port; crystal modes stop the feedback inverter.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         osc_enable <= '0;
         xtal_feedback_en <= 1'b0;
         second_oscillator_pin_out <= 1'b0;
         second_oscillator_pin_oe <= 1'b0;
         clkout_reg <= 1'b0;
      end else if (ce) begin
         osc_enable <= en_next;
         xtal_feedback_en <= xtal_mode && en_next.prim;
         if (src_tick && !pause_reg) begin
            clkout_reg <= ~clkout_reg;
         end
         if (xtal_mode) begin
            second_oscillator_pin_out <= 1'b0;
            second_oscillator_pin_oe <= 1'b0;
         end else if (clkout_mode) begin
            second_oscillator_pin_out <= (mode_reg == cspm_pkg::CSPM_SLEEP) ? 1'b0 : clkout_reg;
            second_oscillator_pin_oe <= 1'b1;
         end else begin
            second_oscillator_pin_out <= port_bit6_out;
            second_oscillator_pin_oe <= port_bit6_oe;
         end
      end
   end

   // ****************************************
   // Power-up delays and status flags
   // ****************************************
   always_comb begin
      ost_done = !xtal_mode || !en_next.prim || (ost_cnt_reg == 11'(`CSPM_OST_TICKS));
      pll_done = (cfg.osc_cfg != cspm_pkg::CSPM_CRYSTAL_PLL_MODE) || (pll_cnt_reg == 32'(PLL_CYC));
      powerup_timer_done = !cfg.powerup_timer_en || (powerup_timer_cnt_reg == 32'(POWERUP_TIMER_CYC));
      ready_done = (ready_cnt_reg == 8'(`CSPM_READY_CYC));
      por_hold = !(powerup_timer_done && ost_done && pll_done);
      device_reset_hold = por_hold;
      exec_ready = !por_hold && ready_done;
      mode = mode_reg;
   end

   // Start-up count restarts whenever the primary oscillator is stopped.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ost_cnt_reg <= 11'h000;
      end else if (ce) begin
         if (!en_next.prim) begin
            ost_cnt_reg <= 11'h000;
         end else if (osc_tick.prim && !ost_done) begin
            ost_cnt_reg <= ost_cnt_reg + 11'h001;
         end
      end
   end

   // Power-up timer and ready delay start at reset release;
   // the PLL lock delay alone waits for the start-up count first.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         powerup_timer_cnt_reg <= 32'h0;
         pll_cnt_reg <= 32'h0;
         ready_cnt_reg <= 8'h00;
      end else if (ce) begin
         if (!powerup_timer_done) begin
            powerup_timer_cnt_reg <= powerup_timer_cnt_reg + 32'h1;
         end
         if (ost_done && !pll_done) begin
            pll_cnt_reg <= pll_cnt_reg + 32'h1;
         end
         if (!ready_done) begin
            ready_cnt_reg <= ready_cnt_reg + 8'h01;
         end
      end
   end

   // Status flags follow hardware only; the bus never writes them.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         startup_timer_done_reg <= cfg.two_speed_start_cfg;
         internal_osc_stable_reg <= 1'b0;
         fast_cnt_reg <= 5'h00;
      end else if (ce) begin
         if (!por_hold) begin
            startup_timer_done_reg <= ost_done && src_pri && en_next.prim;
         end
         if (!en_next.fast) begin
            fast_cnt_reg <= 5'h00;
         end else if (osc_tick.fast && (fast_cnt_reg != 5'(`CSPM_FAST_STABLE_TICKS))) begin
            fast_cnt_reg <= fast_cnt_reg + 5'h01;
         end
         internal_osc_stable_reg <= en_next.fast &&
                                    (fast_cnt_reg == 5'(`CSPM_FAST_STABLE_TICKS));
      end
   end

   // ****************************************
   // AXI4-Lite register access
   // ****************************************
   always_comb begin
      reg_value = {idle_select_reg, internal_freq_select_reg, startup_timer_done_reg,
                   internal_osc_stable_reg, clock_source_select_reg};
      s_axi_awready = !aw_full_reg && !s_axi_bvalid;
      s_axi_wready = !w_full_reg && !s_axi_bvalid;
      s_axi_arready = !s_axi_rvalid;
   end

   // Address and data are caught separately, then written together.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         aw_addr_reg <= '0;
         w_data_reg <= 8'h00;
         w_strb_reg <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
         idle_select_reg <= `CSPM_RST_IDLE;
         internal_freq_select_reg <= `CSPM_RST_FREQ;
         clock_source_select_reg <= `CSPM_RST_SRC;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_reg <= 1'b1;
            w_data_reg <= s_axi_wdata[7:0];
            w_strb_reg <= s_axi_wstrb[0];
         end
         if (aw_full_reg && w_full_reg) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (aw_addr_reg[ADDR_W-1:2] == `CSPM_OSCCTL_OFFSET >> 2) begin
               s_axi_bresp <= 2'h0;
               if (w_strb_reg) begin
                  // Bits 3 and 2 are left alone.
                  idle_select_reg <= w_data_reg[`CSPM_IDLE_BIT];
                  internal_freq_select_reg <= w_data_reg[`CSPM_FREQ_HI:`CSPM_FREQ_LO];
                  clock_source_select_reg <= w_data_reg[`CSPM_SRC_HI:`CSPM_SRC_LO];
               end
            end else begin
               s_axi_bresp <= 2'h2;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Read channel; unmapped addresses answer SLVERR with zero data.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= 2'h0;
      end else if (ce) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            if (s_axi_araddr[ADDR_W-1:2] == `CSPM_OSCCTL_OFFSET >> 2) begin
               s_axi_rdata <= {24'h0, reg_value};
               s_axi_rresp <= 2'h0;
            end else begin
               s_axi_rdata <= 32'h0;
               s_axi_rresp <= 2'h2;
            end
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence s_trig_taken;
      ce && trig_ok && !wake_any;
   endsequence

   sequence s_switch_start;
      ce && new_src_diff;
   endsequence

   a_idle_cpu_off: assert property (ce && cpu_idle(mode_reg) |=> !cpu_tick)
      else $error("core ticked in an idle mode");
   a_sleep_no_tick: assert property (ce && mode_reg == cspm_pkg::CSPM_SLEEP |=> !sys_tick)
      else $error("system ticked in sleep");
   a_switch_pause: assert property (s_switch_start |=> pause_reg && pause_cnt_reg == 4'h0 ##1 !sys_tick)
      else $error("no pause after source switch");
   a_pause_length: assert property ($fell(pause_reg) |-> $past(pause_cnt_reg) == 4'h7)
      else $error("pause length wrong");
   a_trigger_mode: assert property (s_trig_taken ##0 (clock_source_select_reg == 2'h0 && !idle_select_reg)
      |=> mode_reg == cspm_pkg::CSPM_SLEEP)
      else $error("trigger missed sleep");
   a_wake_primary: assert property (ce && wake_any |=> mode_reg == cspm_pkg::CSPM_PRIMARY_RUN_MODE)
      else $error("wake did not reach primary run");
   a_prim_stopped: assert property (ce && !src_pri |=> !osc_enable.prim)
      else $error("primary left running");
   a_watchdog_slow: assert property (ce && cfg.watchdog_en |=> osc_enable.slow)
      else $error("slow oscillator off with watchdog");
   a_ready_delay: assert property (exec_ready |-> ready_cnt_reg == 8'(`CSPM_READY_CYC))
      else $error("execution before ready delay");
   a_pll_hold: assert property (cfg.osc_cfg == cspm_pkg::CSPM_CRYSTAL_PLL_MODE && !pll_done |-> device_reset_hold)
      else $error("released before PLL lock");

endmodule

// ==== bench/cspm_osc_model.sv ====
`timescale 1ns/10ps
// ****************************************
// Oscillator sources
// ****************************************
module cspm_osc_model #(
   parameter int PRIM_PER = 2,
   parameter int SEC_PER = 5,
   parameter int FAST_PER = 2,
   parameter int SLOW_PER = 7
) (
   // Clock
   input wire logic clk,
   // Enables in, ticks out
   input wire cspm_pkg::cspm_osc_t en,
   output cspm_pkg::cspm_osc_t tick
);
   localparam int PER [4] = '{SLOW_PER, FAST_PER, SEC_PER, PRIM_PER};
   int cnt [4];

   // A disabled source stands still, so a stopped clock never leaks a tick.
   always_ff @(posedge clk) begin
      for (int i = 0; i < 4; i++) begin
         if (en[i] !== 1'b1 || cnt[i] >= PER[i] - 1) begin
            cnt[i] <= 0;
         end else begin
            cnt[i] <= cnt[i] + 1;
         end
         tick[i] <= (en[i] === 1'b1) && (cnt[i] == PER[i] - 1);
      end
   end
endmodule

// ==== bench/clock_source_power_mode_ctrl_tb_top.sv ====
`timescale 1ns/10ps
module clock_source_power_mode_ctrl_tb_top;
   logic clk = 0, reset_n = 0, ce = 1, sleep_trigger = 0, wk_i = 0, wk_r = 0, wk_w = 0;
   logic [3:0] awaddr = 0, araddr = 0, strb = 4'hf;
   logic hold, o2, o2_oe;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [31:0] wdata = 0, rdata, rd_val;
   logic [1:0] bresp, rresp, wr_resp, rd_resp, st;
   logic awready, wready, bvalid, arready, rvalid, sys_tick, cpu_tick, periph_tick, fb_en, rdy;
   cspm_pkg::cspm_osc_t osc_en, osc_tick;
   cspm_pkg::cspm_mode_t mode;
   cspm_pkg::cspm_cfg_t cfg = '{cspm_pkg::CSPM_HS, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
   int bad_count = 0, checks = 0;
   logic [7:0] val [6] = '{8'h00, 8'h80, 8'h01, 8'h81, 8'h02, 8'hf3};
   cspm_pkg::cspm_mode_t md [6] = '{cspm_pkg::CSPM_SLEEP, cspm_pkg::CSPM_PRIMARY_IDLE_MODE,
      cspm_pkg::CSPM_SECONDARY_RUN_MODE, cspm_pkg::CSPM_SECONDARY_IDLE_MODE, cspm_pkg::CSPM_INT_RUN,
      cspm_pkg::CSPM_INT_IDLE};

   // Free-running system clock.
   always #20 clk = ~clk;

   cspm_ctrl #(.POWERUP_TIMER_CYC(20), .PLL_CYC(30)) uut (.clk(clk), .reset_n(reset_n), .ce(ce),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .cfg(cfg), .osc_tick(osc_tick), .sleep_trigger(sleep_trigger),
      .wake_interrupt(wk_i), .wake_reset(wk_r), .wake_watchdog(wk_w),
      .port_bit6_out(1'b0), .port_bit6_oe(1'b0), .osc_enable(osc_en), .sys_tick(sys_tick),
      .cpu_tick(cpu_tick), .periph_tick(periph_tick), .device_reset_hold(hold),
      .exec_ready(rdy), .mode(mode), .xtal_feedback_en(fb_en), .second_oscillator_pin_out(o2), .second_oscillator_pin_oe(o2_oe));

   cspm_osc_model osc (.clk(clk), .en(osc_en), .tick(osc_tick));

   // ****************************************
   // Bus and check tasks
   // ****************************************
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Ready is sampled mid-cycle; inputs only move after a rising edge, so it is settled.
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      logic ta, tw, tb;
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      do begin
         @(negedge clk);
         ta = awvalid & awready;
         tw = wvalid & wready;
         tb = bready & bvalid;
         wr_resp = bresp;
         @(posedge clk);
         if (ta) awvalid <= 0;
         if (tw) wvalid <= 0;
         if (tb) bready <= 0;
      end while (!tb);
      @(posedge clk);
   endtask

   task automatic rd(input logic [3:0] a);
      logic ta, tr;
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do begin
         @(negedge clk);
         ta = arvalid & arready;
         tr = rready & rvalid;
         rd_val = rdata;
         rd_resp = rresp;
         @(posedge clk);
         if (ta) arvalid <= 0;
         if (tr) rready <= 0;
      end while (!tr);
      @(posedge clk);
   endtask

   task automatic wait_ready;
      int n;
      n = 0;
      while (rdy !== 1'b1 && n < 6000) begin
         @(negedge clk);
         n++;
      end
      chk("exec_ready", rdy, 1);
      @(posedge clk);
   endtask

   task automatic end_of_test;
      if (bad_count == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ****************************************
   // Tests
   // ****************************************
   // Startup alone takes about 2100 cycles and each mode pass up to 2500 more.
   initial begin
      tick(30000);
      bad_count++;
      end_of_test;
   end

   initial begin
      int nc, np, n0;
      tick(8);
      reset_n <= 1;
      rd(0);
      chk("reset value", rd_val, 32'h0);
      wait_ready;
      rd(0);
      chk("startup flag", rd_val & 32'h8, 32'h8);
      st = rd_val[3:2];
      wr(0, 8'h0c);
      rd(0);
      chk("status bits", rd_val[3:2], st);
      wr(0, 8'h03);
      @(negedge clk);
      chk("mode", mode, cspm_pkg::CSPM_PRIMARY_RUN_MODE);
      // A cleared byte strobe must leave the whole register as it was.
      @(posedge clk);
      strb <= 4'h0;
      wr(0, 8'hf0);
      strb <= 4'hf;
      rd(0);
      chk("source field", rd_val & 32'hf3, 32'h03);
      // With the clock enable low the trigger is lost, so the mode stays put.
      ce <= 0;
      sleep_trigger <= 1;
      tick(1);
      ce <= 1;
      sleep_trigger <= 0;
      tick(1);
      @(negedge clk);
      chk("frozen mode", mode, cspm_pkg::CSPM_PRIMARY_RUN_MODE);
      @(posedge clk);
      rd(4'h4);
      chk("unmapped read", rd_resp, 2'b10);
      wr(4'h8, 8'h00);
      chk("unmapped write", wr_resp, 2'b10);
      // The trigger from a run mode at i 2 is followed by a second one, without a wake.
      for (int i = 0; i < 6; i++) begin
         wait_ready;
         wr(0, val[i]);
         sleep_trigger <= 1;
         tick(1);
         sleep_trigger <= 0;
         tick(2);
         @(negedge clk);
         chk("mode", mode, md[i]);
         n0 = 0;
         repeat (14) begin
            @(negedge clk);
            if (sys_tick === 1'b1) n0++;
         end
         if (i == 2 || i == 4 || i == 5) chk("pause", n0, 0);
         repeat (70) @(negedge clk);
         nc = 0;
         np = 0;
         repeat (60) begin
            @(negedge clk);
            if (cpu_tick === 1'b1) nc++;
            if (periph_tick === 1'b1) np++;
         end
         chk("cpu clock", nc != 0,
             md[i] inside {cspm_pkg::CSPM_SECONDARY_RUN_MODE, cspm_pkg::CSPM_INT_RUN});
         chk("periph clock", np != 0,
             md[i] != cspm_pkg::CSPM_SLEEP);
         chk("primary enable", osc_en.prim, md[i] == cspm_pkg::CSPM_PRIMARY_IDLE_MODE);
         chk("fast enable", osc_en.fast, md[i] == cspm_pkg::CSPM_INT_IDLE);
         chk("slow enable", osc_en.slow, 1);
         chk("second_oscillator_pin pin", {o2, o2_oe}, 2'h0);
         if (md[i] == cspm_pkg::CSPM_SLEEP) chk("feedback", fb_en, 0);
         // Only primary idle keeps the start-up flag; only a running fast source is stable.
         @(posedge clk);
         rd(0);
         chk("startup flag", rd_val[3], md[i] == cspm_pkg::CSPM_PRIMARY_IDLE_MODE);
         chk("stable flag", rd_val[2], md[i] == cspm_pkg::CSPM_INT_IDLE);
         if (i != 2) begin
            tick(1);
            wk_i <= (i % 3 == 0);
            wk_r <= (i % 3 == 1);
            wk_w <= (i % 3 == 2);
            tick(1);
            wk_i <= 0;
            wk_r <= 0;
            wk_w <= 0;
            tick(2);
            @(negedge clk);
            chk("wake mode", mode, cspm_pkg::CSPM_PRIMARY_RUN_MODE);
            tick(40);
         end else begin
            tick(1);
         end
      end
      // Second start from reset in mid-run, now in PLL mode with two-speed start set.
      cfg <= '{cspm_pkg::CSPM_CRYSTAL_PLL_MODE, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
      reset_n <= 0;
      tick(8);
      reset_n <= 1;
      rd(0);
      @(negedge clk);
      chk("reset hold", hold, 1);
      chk("reset flag", rd_val[3], 1);
      wait_ready;
      @(negedge clk);
      chk("hold released", hold, 0);
      end_of_test;
   end
endmodule
